// ### pcs_sequencer.sv
// pcs_sequencer: primary cache maintenance sequencer with a wishbone register port
// assumes pipeline hazard inputs on sys_clk_in; memory done strobes come from pins
`timescale 1ns/10ps
module pcs_sequencer (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic icache_miss_in,
    input wire logic dcache_miss_in,
    input wire logic ext_req_in,
    input wire logic store_buf_empty_in,
    input wire logic resp_buf_empty_in,
    input wire logic wb_done_in,
    input wire logic fill_last_in,
    output logic busy_out,
    output logic wb_req_out,
    output logic [31:0] wb_addr_out,
    output logic fill_req_out,
    output logic [31:0] fill_addr_out
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_WAIT = 7'h02, ST_RUN = 7'h04, ST_FBASE = 7'h08,
        ST_FALIGN = 7'h10, ST_FBUS = 7'h20, ST_FMEM = 7'h40
    } pcs_state_t;

    pcs_state_t state_reg, state_next;
    pcs_pkg::pcs_line_t dline_reg [pcs_pkg::LINES];
    pcs_pkg::pcs_line_t iline_reg [pcs_pkg::LINES];
    pcs_pkg::pcs_line_t dline_next [pcs_pkg::LINES];
    pcs_pkg::pcs_line_t iline_next [pcs_pkg::LINES];
    logic [3:0] op_reg, op_next;
    logic go_reg, go_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] low_tag_register_reg, low_tag_register_next;
    logic [31:0] high_tag_register_reg, high_tag_register_next;
    logic [pcs_pkg::PAR_W-1:0] check_reg, check_next;
    logic [3:0] div_reg, div_next;
    logic ce_reg, ce_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic busy_reg, busy_next;
    logic wbreq_reg, wbreq_next;
    logic [31:0] wbaddr_reg, wbaddr_next;
    logic fillreq_reg, fillreq_next;
    logic last_hit_reg, last_hit_next;
    logic last_wb_reg, last_wb_next;
    logic [7:0] cycles_reg, cycles_next;
    logic [1:0] ticks_reg, ticks_next;
    logic [2:0] wbd_sync_reg, fl_sync_reg;
    logic timer_load;
    logic [pcs_pkg::CNT_W-1:0] timer_value;
    logic timer_zero;
    logic tick_zero;
    logic wb_done_evt, fill_evt;
    logic access;
    logic [pcs_pkg::IDX_W-1:0] idx;
    logic [pcs_pkg::TAG_W-1:0] tag;
    pcs_pkg::pcs_line_t line;
    logic hit;
    logic is_icache;
    logic [pcs_pkg::PAR_W-1:0] calc_par;

    // memory strobes come from pins: two flops, then a third only for the edge
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            wbd_sync_reg <= 3'h0;
            fl_sync_reg <= 3'h0;
        end
        else
        begin
            wbd_sync_reg <= {wbd_sync_reg[1:0], wb_done_in};
            fl_sync_reg <= {fl_sync_reg[1:0], fill_last_in};
        end
    end
    assign wb_done_evt = wbd_sync_reg[1] & ~wbd_sync_reg[2];
    assign fill_evt = fl_sync_reg[1] & ~fl_sync_reg[2];

    // op length timer and the system cycle divider
    pcs_down_counter #(.WIDTH(pcs_pkg::CNT_W)) u_timer (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(timer_load),
        .load_value_in(timer_value),
        .zero_out(timer_zero)
    );
    pcs_down_counter #(.WIDTH(4)) u_system_clock_divisor (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(tick_zero),
        .load_value_in(div_reg - 4'h1),
        .zero_out(tick_zero)
    );

    // line lookup for the operation address
    assign idx = addr_reg[pcs_pkg::IDX_LSB +: pcs_pkg::IDX_W];
    assign tag = addr_reg[31 -: pcs_pkg::TAG_W];
    assign is_icache = op_reg[3];
    assign line = is_icache ? iline_reg[idx] : dline_reg[idx];
    assign hit = line.valid && (line.tag == tag);
    assign calc_par = {^addr_reg[31:24], ^addr_reg[23:16], ^addr_reg[15:8], ^addr_reg[7:0]};
    assign access = wb_cyc_in & wb_stb_in & ~ack_reg;

    // sequencer, register file and arrays share one next-state process
    always_comb
    begin
        pcs_pkg::pcs_line_t nl;
        logic wr, wb;
        logic [pcs_pkg::CNT_W-1:0] n;
        nl = line;
        wr = 1'b0;
        wb = 1'b0;
        n = pcs_pkg::CY_7;
        state_next = state_reg;
        dline_next = dline_reg;
        iline_next = iline_reg;
        op_next = op_reg;
        go_next = go_reg;
        addr_next = addr_reg;
        low_tag_register_next = low_tag_register_reg;
        high_tag_register_next = high_tag_register_reg;
        check_next = check_reg;
        div_next = div_reg;
        ce_next = ce_reg;
        wbreq_next = wbreq_reg;
        wbaddr_next = wbaddr_reg;
        fillreq_next = fillreq_reg;
        last_hit_next = last_hit_reg;
        last_wb_next = last_wb_reg;
        cycles_next = cycles_reg;
        ticks_next = ticks_reg;
        timer_load = 1'b0;
        timer_value = '0;
        ack_next = access;
        rdat_next = 32'h0;
        // bus side; op setup registers are frozen while an op is in flight
        if (access && wb_we_in && wb_sel_in == 4'hF && state_reg == pcs_state_t'(ST_IDLE)
            && !go_reg)
        begin
            case (wb_adr_in)
                pcs_pkg::REG_CTRL:
                begin
                    op_next = wb_dat_in[3:0];
                    go_next = wb_dat_in[pcs_pkg::CTRL_GO_BIT];
                end
                pcs_pkg::REG_ADDR: addr_next = wb_dat_in;
                pcs_pkg::REG_LOW_TAG_REGISTER: low_tag_register_next = wb_dat_in;
                pcs_pkg::REG_HIGH_TAG_REGISTER: high_tag_register_next = wb_dat_in;
                pcs_pkg::REG_CHECK: check_next = wb_dat_in[pcs_pkg::PAR_W-1:0];
                pcs_pkg::REG_CFG:
                begin
                    // out of range divisors clamp to the supported span
                    if (wb_dat_in[3:0] < pcs_pkg::DIV_MIN)
                        div_next = pcs_pkg::DIV_MIN;
                    else if (wb_dat_in[3:0] > pcs_pkg::DIV_MAX)
                        div_next = pcs_pkg::DIV_MAX;
                    else
                        div_next = wb_dat_in[3:0];
                    ce_next = wb_dat_in[pcs_pkg::CFG_CE_BIT];
                end
                default: ;
            endcase
        end
        if (access && !wb_we_in)
        begin
            case (wb_adr_in)
                pcs_pkg::REG_CTRL: rdat_next = {22'h0, wbreq_reg, busy_reg, 3'h0, go_reg, op_reg};
                pcs_pkg::REG_ADDR: rdat_next = addr_reg;
                pcs_pkg::REG_LOW_TAG_REGISTER: rdat_next = low_tag_register_reg;
                pcs_pkg::REG_HIGH_TAG_REGISTER: rdat_next = high_tag_register_reg;
                pcs_pkg::REG_CHECK: rdat_next = {28'h0, check_reg};
                pcs_pkg::REG_CFG: rdat_next = {23'h0, ce_reg, 4'h0, div_reg};
                pcs_pkg::REG_RESULT: rdat_next = {22'h0, last_wb_reg, last_hit_reg, cycles_reg};
                default: rdat_next = 32'h0;
            endcase
        end
        // the writeback buffer drains when memory reports done
        if (wb_done_evt)
            wbreq_next = 1'b0;
        if (state_reg != pcs_state_t'(ST_IDLE) && state_reg != pcs_state_t'(ST_WAIT))
            cycles_next = cycles_reg + 8'h01;
        case (state_reg)
            ST_IDLE:
                if (go_reg)
                    state_next = ST_WAIT;
            ST_WAIT:
                // misses, external requests and a full writeback buffer go first
                if (!icache_miss_in && !dcache_miss_in && !ext_req_in && !wbreq_reg
                    && (is_icache || (store_buf_empty_in && resp_buf_empty_in)))
                begin
                    go_next = 1'b0;
                    cycles_next = 8'h00;
                    last_hit_next = hit;
                    wr = 1'b1;
                    state_next = ST_RUN;
                    case (op_reg)
                        pcs_pkg::OP_IDX_WBINV_D:
                        begin
                            wb = line.valid & line.dirty;
                            nl.valid = 1'b0;
                            n = wb ? pcs_pkg::CY_12 : pcs_pkg::CY_10;
                        end
                        pcs_pkg::OP_IDX_LDTAG_D, pcs_pkg::OP_IDX_LDTAG_I:
                        begin
                            wr = 1'b0;
                            // parity is not checked on this read
                            low_tag_register_next = {line.tag, 5'h0, line.valid, line.dirty};
                            check_next = line.parity;
                            n = pcs_pkg::CY_7;
                        end
                        pcs_pkg::OP_IDX_STTAG_D, pcs_pkg::OP_IDX_STTAG_I:
                        begin
                            nl.tag = low_tag_register_reg[31 -: pcs_pkg::TAG_W];
                            nl.valid = low_tag_register_reg[pcs_pkg::LOW_TAG_REGISTER_V_BIT];
                            nl.dirty = low_tag_register_reg[pcs_pkg::LOW_TAG_REGISTER_D_BIT];
                            nl.parity = high_tag_register_reg[pcs_pkg::PAR_W-1:0];
                            n = pcs_pkg::CY_8;
                        end
                        pcs_pkg::OP_CREATE_DE_D:
                        begin
                            wb = !hit & line.valid & line.dirty;
                            nl.tag = tag;
                            nl.valid = 1'b1;
                            nl.dirty = 1'b1;
                            n = hit ? pcs_pkg::CY_10 : (wb ? pcs_pkg::CY_15 : pcs_pkg::CY_13);
                        end
                        pcs_pkg::OP_HIT_INV_D, pcs_pkg::OP_HIT_INV_I:
                        begin
                            nl.valid = line.valid & !hit;
                            n = hit ? pcs_pkg::CY_9 : pcs_pkg::CY_7;
                        end
                        pcs_pkg::OP_HIT_WBINV_D:
                        begin
                            wb = hit & line.dirty;
                            nl.valid = line.valid & !hit;
                            n = !hit ? pcs_pkg::CY_7 : (wb ? pcs_pkg::CY_14 : pcs_pkg::CY_12);
                        end
                        pcs_pkg::OP_HIT_WB_D:
                        begin
                            wb = hit & line.dirty;
                            nl.dirty = line.dirty & !hit;
                            n = !hit ? pcs_pkg::CY_7 : (wb ? pcs_pkg::CY_14 : pcs_pkg::CY_10);
                        end
                        pcs_pkg::OP_IDX_INV_I:
                        begin
                            nl.valid = 1'b0;
                            nl.tag = tag;
                            n = pcs_pkg::CY_7;
                        end
                        pcs_pkg::OP_HIT_WB_I:
                        begin
                            wr = 1'b0;
                            wb = hit;
                            n = hit ? pcs_pkg::CY_20 : pcs_pkg::CY_7;
                        end
                        pcs_pkg::OP_FILL_I:
                        begin
                            // the line is written when the last word lands
                            wr = 1'b0;
                            n = pcs_pkg::FILL_BASE;
                            state_next = ST_FBASE;
                        end
                        default:
                        begin
                            // unknown codes complete as a no-op
                            wr = 1'b0;
                            n = pcs_pkg::CY_7;
                        end
                    endcase
                    timer_load = 1'b1;
                    timer_value = n - 5'h01;
                    last_wb_next = wb;
                    if (wb)
                    begin
                        // the stored tag names the line, not the op address
                        wbreq_next = 1'b1;
                        wbaddr_next = {line.tag, idx, 4'h0};
                    end
                end
            ST_RUN:
                if (timer_zero)
                    state_next = ST_IDLE;
            ST_FBASE:
                if (timer_zero)
                    state_next = ST_FALIGN;
            ST_FALIGN:
                // waits 0 to divisor-1 cycles for a system cycle boundary
                if (tick_zero)
                begin
                    ticks_next = pcs_pkg::FILL_BUS_TICKS - 2'h1;
                    state_next = ST_FBUS;
                end
            ST_FBUS:
                if (tick_zero)
                begin
                    ticks_next = ticks_reg - 2'h1;
                    if (ticks_reg == 2'h0)
                    begin
                        fillreq_next = 1'b1;
                        state_next = ST_FMEM;
                    end
                end
            ST_FMEM:
                // latency and transfer time belong to the memory agent
                if (fill_evt)
                begin
                    fillreq_next = 1'b0;
                    wr = 1'b1;
                    nl.tag = tag;
                    nl.valid = 1'b1;
                    nl.dirty = 1'b0;
                    nl.parity = ce_reg ? check_reg : calc_par;
                    state_next = ST_IDLE;
                end
            default: state_next = ST_IDLE;
        endcase
        if (wr)
        begin
            if (is_icache)
                iline_next[idx] = nl;
            else
                dline_next[idx] = nl;
        end
        // busy stays up from go through every state wait, including the fill; a pending writeback can outlast it
        busy_next = go_next || (state_next != pcs_state_t'(ST_IDLE));
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_reg <= ST_IDLE;
            for (int i = 0; i < pcs_pkg::LINES; i++)
            begin
                dline_reg[i] <= '0;
                iline_reg[i] <= '0;
            end
            op_reg <= 4'h0;
            go_reg <= 1'b0;
            addr_reg <= 32'h0;
            low_tag_register_reg <= 32'h0;
            high_tag_register_reg <= 32'h0;
            check_reg <= '0;
            div_reg <= pcs_pkg::DIV_RESET;
            ce_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
            busy_reg <= 1'b0;
            wbreq_reg <= 1'b0;
            wbaddr_reg <= 32'h0;
            fillreq_reg <= 1'b0;
            last_hit_reg <= 1'b0;
            last_wb_reg <= 1'b0;
            cycles_reg <= 8'h00;
            ticks_reg <= 2'h0;
        end
        else
        begin
            state_reg <= state_next;
            dline_reg <= dline_next;
            iline_reg <= iline_next;
            op_reg <= op_next;
            go_reg <= go_next;
            addr_reg <= addr_next;
            low_tag_register_reg <= low_tag_register_next;
            high_tag_register_reg <= high_tag_register_next;
            check_reg <= check_next;
            div_reg <= div_next;
            ce_reg <= ce_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            busy_reg <= busy_next;
            wbreq_reg <= wbreq_next;
            wbaddr_reg <= wbaddr_next;
            fillreq_reg <= fillreq_next;
            last_hit_reg <= last_hit_next;
            last_wb_reg <= last_wb_next;
            cycles_reg <= cycles_next;
            ticks_reg <= ticks_next;
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;
    assign busy_out = busy_reg;
    assign wb_req_out = wbreq_reg;
    assign wb_addr_out = wbaddr_reg;
    assign fill_req_out = fillreq_reg;
    assign fill_addr_out = {addr_reg[31:4], 4'h0};
endmodule : pcs_sequencer

// ### pcs_pkg.sv
// pcs_pkg: constants, op codes and the line record for the cache op sequencer
// assumes a 25 MHz single clock and a classic wishbone slave with byte addresses
package pcs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_LOW_TAG_REGISTER = 8'h08;
    localparam logic [7:0] REG_HIGH_TAG_REGISTER = 8'h0C;
    localparam logic [7:0] REG_CHECK = 8'h10;
    localparam logic [7:0] REG_CFG = 8'h14;
    localparam logic [7:0] REG_RESULT = 8'h18;
    // field positions
    localparam int CTRL_GO_BIT = 4;
    localparam int CTRL_BUSY_BIT = 8;
    localparam int CTRL_WBFULL_BIT = 9;
    localparam int CFG_CE_BIT = 8;
    localparam int LOW_TAG_REGISTER_TAG_LSB = 7;
    localparam int LOW_TAG_REGISTER_V_BIT = 1;
    localparam int LOW_TAG_REGISTER_D_BIT = 0;
    localparam int RES_HIT_BIT = 8;
    localparam int RES_WB_BIT = 9;
    // geometry
    localparam int LINES = 8;
    localparam int IDX_W = 3;
    localparam int IDX_LSB = 4;
    localparam int TAG_W = 25;
    localparam int PAR_W = 4;
    localparam int CNT_W = 5;
    // divisor
    localparam logic [3:0] DIV_MIN = 4'h2;
    localparam logic [3:0] DIV_MAX = 4'h8;
    localparam logic [3:0] DIV_RESET = 4'h2;
    // cycle figures
    localparam logic [CNT_W-1:0] CY_7 = 5'h07;
    localparam logic [CNT_W-1:0] CY_8 = 5'h08;
    localparam logic [CNT_W-1:0] CY_9 = 5'h09;
    localparam logic [CNT_W-1:0] CY_10 = 5'h0A;
    localparam logic [CNT_W-1:0] CY_12 = 5'h0C;
    localparam logic [CNT_W-1:0] CY_13 = 5'h0D;
    localparam logic [CNT_W-1:0] CY_14 = 5'h0E;
    localparam logic [CNT_W-1:0] CY_15 = 5'h0F;
    localparam logic [CNT_W-1:0] CY_20 = 5'h14;
    localparam logic [CNT_W-1:0] FILL_BASE = 5'h0A;
    localparam logic [1:0] FILL_BUS_TICKS = 2'h2;
    // op codes, bit 3 selects the instruction cache
    typedef enum logic [3:0] {
        OP_IDX_WBINV_D = 4'h0, OP_IDX_LDTAG_D = 4'h1, OP_IDX_STTAG_D = 4'h2,
        OP_CREATE_DE_D = 4'h3, OP_HIT_INV_D = 4'h4, OP_HIT_WBINV_D = 4'h5,
        OP_HIT_WB_D = 4'h6, OP_IDX_INV_I = 4'h8, OP_IDX_LDTAG_I = 4'h9,
        OP_IDX_STTAG_I = 4'hA, OP_HIT_INV_I = 4'hB, OP_FILL_I = 4'hC,
        OP_HIT_WB_I = 4'hD
    } pcs_op_t;
    // one cache line's bookkeeping
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic valid;
        logic dirty;
        logic [PAR_W-1:0] parity;
    } pcs_line_t;
endpackage : pcs_pkg

// ### pcs_down_counter.sv
// pcs_down_counter: loadable down counter with a zero flag
// assumes a synchronous active high reset on the processor clock
`timescale 1ns/10ps
module pcs_down_counter #(
    parameter int WIDTH = 5
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_value_in,
    output logic zero_out
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // load wins; otherwise count down and rest at zero
    always_comb
    begin
        count_next = count_reg;
        if (load_in)
            count_next = load_value_in;
        else if (count_reg != '0)
            count_next = count_reg - 1'b1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    assign zero_out = (count_reg == '0);
endmodule : pcs_down_counter

// ### pcs_mem_model.sv
// pcs_mem_model: memory side answering writeback and fill requests
// assumes requests are levels held until the answer strobe is seen
`timescale 1ns/10ps
module pcs_mem_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] delay_in,
    input wire logic wb_req_in,
    input wire logic fill_req_in,
    output logic wb_done_out = 1'b0,
    output logic fill_last_out = 1'b0
);
    int wait_cnt = 0;
    // answers are held until the request drops, so a slow sync never misses them
    always @(posedge clk_in)
    begin
        wait_cnt <= (wb_req_in || fill_req_in) && !rst_in ? wait_cnt + 1 : 0;
        wb_done_out <= !rst_in && wb_req_in && wait_cnt > delay_in;
        fill_last_out <= !rst_in && fill_req_in && wait_cnt > delay_in + 2;
    end
endmodule : pcs_mem_model

// ### pcs_sequencer_asserts.sv
// pcs_sequencer_asserts: port-level properties of the cache op sequencer
// assumes it is bound into pcs_sequencer and sees only its ports
`timescale 1ns/10ps
module pcs_sequencer_asserts (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic busy_out,
    input wire logic wb_req_out,
    input wire logic [31:0] wb_addr_out,
    input wire logic wb_done_in,
    input wire logic fill_req_out,
    input wire logic fill_last_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // bus answers: one-cycle ack, zero from unmapped space
    property p_ack_rsp; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_rsp: assert property (p_ack_rsp) else $error("ack missing");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_unmapped; wb_ack_out && !wb_we_in && wb_adr_in == 8'h1C |-> wb_dat_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // shortest op is a wait cycle plus seven run cycles
    property p_busy_min; $rose(busy_out) |-> busy_out [*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_fill_busy; fill_req_out |-> busy_out; endproperty
    a_fill_busy: assert property (p_fill_busy) else $error("fill without busy");
    // requests drop only after the memory side answered
    property p_wb_drop; $fell(wb_req_out) |-> $past(wb_done_in) || $past(sys_rst_in); endproperty
    a_wb_drop: assert property (p_wb_drop) else $error("writeback dropped early");
    property p_fill_drop; $fell(fill_req_out) |-> $past(fill_last_in) || $past(sys_rst_in);
    endproperty
    a_fill_drop: assert property (p_fill_drop) else $error("fill dropped early");
    property p_wb_hold; wb_req_out && $past(wb_req_out) |-> $stable(wb_addr_out); endproperty
    a_wb_hold: assert property (p_wb_hold) else $error("writeback address moved");
endmodule : pcs_sequencer_asserts
bind pcs_sequencer pcs_sequencer_asserts u_chk (.sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .busy_out(busy_out), .wb_req_out(wb_req_out), .wb_addr_out(wb_addr_out),
    .wb_done_in(wb_done_in), .fill_req_out(fill_req_out), .fill_last_in(fill_last_in));

// ### tb_top.sv
// tb_top: self-checking bench for the cache op sequencer
// assumes the memory model answers writebacks and fills
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [4:0] hz = 5'h18; // imiss, dmiss, ext, store empty, resp empty
    logic [31:0] dat = 32'h0, rdat, waddr, faddr, q, ewa, ba, lfsr = 32'h0000002D;
    logic ack, busy, wreq, freq, wdone, flast, ewb;
    logic [24:0] mt [16];
    logic mv [16], md [16];
    logic [4:0] seq [25] = '{5'h02, 5'h01, 5'h06, 5'h06, 5'h05, 5'h05, 5'h03, 5'h03, 5'h13,
        5'h01, 5'h00, 5'h00, 5'h02, 5'h04, 5'h04, 5'h0A, 5'h09, 5'h0B, 5'h08, 5'h0A, 5'h1D,
        5'h0D, 5'h0C, 5'h0D, 5'h07};
    logic [31:0] cfg_w [3] = '{32'h101, 32'h009, 32'h105};
    logic [31:0] cfg_r [3] = '{32'h102, 32'h008, 32'h105};
    int err_count = 0, tests_run = 0, cyc_cnt = 0, n, kk;
    always #20 clk = ~clk;
    pcs_sequencer dut (.sys_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .icache_miss_in(hz[0]), .dcache_miss_in(hz[1]), .ext_req_in(hz[2]),
        .store_buf_empty_in(hz[3]), .resp_buf_empty_in(hz[4]), .wb_done_in(wdone),
        .fill_last_in(flast), .busy_out(busy), .wb_req_out(wreq), .wb_addr_out(waddr),
        .fill_req_out(freq), .fill_addr_out(faddr));
    pcs_mem_model mem (.clk_in(clk), .rst_in(rst), .delay_in(lfsr[3:0]), .wb_req_in(wreq),
        .fill_req_in(freq), .wb_done_out(wdone), .fill_last_out(flast));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // classic single cycle, held until ack is sampled
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask : wb_xfer
    // line bookkeeping: expected cycles, writeback flag and address
    task automatic model(input logic [3:0] op, input logic [31:0] a);
        logic h, d;
        kk = {op[3], a[6:4]};
        h = mv[kk] && mt[kk] == a[31:7];
        d = mv[kk] && md[kk];
        ewa = {mt[kk], a[6:4], 4'h0};
        ewb = (op == 4'h0 && d) || (op == 4'h3 && !h && d) || (op inside {4'h5, 4'h6} && h && d)
            || (op == 4'hD && h);
        case (op)
            4'h0: n = d ? 12 : 10;
            4'h2, 4'hA: n = 8;
            4'h3: n = h ? 10 : (d ? 15 : 13);
            4'h4, 4'hB: n = h ? 9 : 7;
            4'h5: n = h ? (ewb ? 14 : 12) : 7;
            4'h6: n = h ? (ewb ? 14 : 10) : 7;
            4'hD: n = h ? 20 : 7;
            default: n = 7;
        endcase
        if (op == 4'h0 || (op inside {4'h4, 4'h5, 4'hB} && h)) mv[kk] = 1'b0;
        if (op == 4'h6 && h) md[kk] = 1'b0;
        if (op inside {4'h2, 4'hA, 4'h3, 4'h8, 4'hC})
            {mt[kk], mv[kk], md[kk]} = {a[31:7], op != 4'h8, op != 4'hC};
    endtask : model
    // one op with a hazard held long enough that a premature start of any op but the fill would end
    task automatic run_op(input logic [3:0] op, input logic [31:0] a);
        wb_xfer(1'b1, pcs_pkg::REG_ADDR, a);
        wb_xfer(1'b1, pcs_pkg::REG_LOW_TAG_REGISTER, {a[31:7], 7'h03});
        model(op, a);
        lfsr = nxt(lfsr);
        hz <= 5'h18 ^ 5'(5'h01 << (lfsr % (op[3] ? 3 : 5)));
        wb_xfer(1'b1, pcs_pkg::REG_CTRL, {27'h0, 1'b1, op});
        repeat (24) @(posedge clk);
        wb_xfer(1'b1, pcs_pkg::REG_ADDR, ~a);
        chk({31'h0, busy}, 32'h1);
        hz <= 5'h18;
        do @(posedge clk); while (busy !== 1'b0);
        wb_xfer(1'b0, pcs_pkg::REG_ADDR, 32'h0);
        chk(q, a);
        wb_xfer(1'b0, pcs_pkg::REG_RESULT, 32'h0);
        if (op != 4'hC) chk(32'({q[9], q[7:0]}), 32'({ewb, n[7:0]}));
        if (op == 4'hC) chk(32'(q[7:0] >= 8'h14), 32'h1);
        if (op == 4'hC) chk(faddr, {a[31:4], 4'h0});
        if (ewb) chk(waddr, ewa);
        wb_xfer(1'b0, pcs_pkg::REG_LOW_TAG_REGISTER, 32'h0);
        if (op[2:0] == 3'h1) chk(q & 32'hFFFFFF83, {mt[kk], 5'h0, mv[kk], md[kk]});
    endtask : run_op
    // hang guard
    always @(posedge clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        for (int i = 0; i < 16; i++) {mt[i], mv[i], md[i]} = 27'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb_xfer(1'b0, pcs_pkg::REG_CFG, 32'h0);
        chk(q, 32'(pcs_pkg::DIV_RESET));
        wb_xfer(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        sel <= 4'h3;
        wb_xfer(1'b1, pcs_pkg::REG_ADDR, 32'h55);
        sel <= 4'hF;
        wb_xfer(1'b0, pcs_pkg::REG_ADDR, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wb_xfer(1'b1, pcs_pkg::REG_CFG, cfg_w[i]);
            wb_xfer(1'b0, pcs_pkg::REG_CFG, 32'h0);
            chk(q, cfg_r[i]);
        end
        for (int it = 0; it < 3; it++)
        begin
            // one line index per pass so the hit paths are reached
            lfsr = nxt(lfsr);
            ba = lfsr;
            foreach (seq[j]) run_op(seq[j][3:0], ba ^ 32'({seq[j][4], 7'h0}));
        end
        tally_and_finish();
    end
endmodule : tb_top
